// ===== fsc_pkg.sv
package fsc_pkg;

  // Register word offsets (byte addresses on the 32-bit bus)
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PREDIV = 6'h04;
  localparam logic [5:0] OFF_DIVOUT = 6'h08;
  localparam logic [5:0] OFF_INT = 6'h0c;
  localparam logic [5:0] OFF_FRAC = 6'h10;
  localparam logic [5:0] OFF_MODE = 6'h14;
  localparam logic [5:0] OFF_CAL = 6'h18;
  localparam logic [5:0] OFF_NDIV = 6'h1c;
  localparam logic [5:0] OFF_STATUS = 6'h20;

  // Control register bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_AUTO = 2;

  // Status register bit positions and field
  localparam int STAT_BUSY = 0;
  localparam int STAT_POWER = 1;
  localparam int STAT_DIV_LSB = 8;

  // Field widths
  localparam int DIV_W = 8;
  localparam int INT_W = 8;
  localparam int FRAC_W = 24;
  localparam int CAL_W = 8;
  localparam int N_W = 4;

  // Reference predivider codes and their divide counts
  localparam logic [1:0] PREDIV_BY1 = 2'h0;
  localparam logic [1:0] PREDIV_BY2 = 2'h1;
  localparam logic [1:0] PREDIV_BY4 = 2'h2;
  localparam logic [1:0] PREDIV_BY8 = 2'h3;
  localparam logic [2:0] PREDIV_CNT1 = 3'h0;
  localparam logic [2:0] PREDIV_CNT2 = 3'h1;
  localparam logic [2:0] PREDIV_CNT4 = 3'h3;
  localparam logic [2:0] PREDIV_CNT8 = 3'h7;

  // Scale mode: a set bit bypasses its factor, so code 3 bypasses both
  localparam int MODE_B500_BIT = 0;
  localparam int MODE_B1029_BIT = 1;
  localparam logic [1:0] MODE_BYPASS_BOTH = 2'h3;

  // Reset values
  localparam logic [1:0] RST_PREDIV = 2'h0;
  localparam logic [7:0] RST_DIVOUT = 8'h10;
  localparam logic [7:0] RST_INT = 8'h40;
  localparam logic [23:0] RST_FRAC = 24'h000000;
  localparam logic [1:0] RST_MODE = 2'h3;
  localparam logic [7:0] RST_CAL = 8'h80;
  localparam logic [3:0] RST_NDIV = 4'h1;

  // Restore wait after power-up, in its own unit and in clock cycles
  localparam int SEQ_WAIT_US = 800;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int SEQ_WAIT_CYC = SEQ_WAIT_US * CLK_FREQ_MHZ;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fsc_bus_req_t;

  // Settings driven into the analog synthesizer core
  typedef struct packed {
    logic power_on;
    logic bypass_500;
    logic bypass_1029;
    logic [INT_W-1:0] int_factor;
    logic [FRAC_W-1:0] frac_factor;
    logic [CAL_W-1:0] cal_ratio;
    logic [DIV_W-1:0] out_divider;
  } fsc_synth_cfg_t;

  // Power-up sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b001,
    SEQ_WAIT = 3'b010,
    SEQ_RUN = 3'b100
  } fsc_seq_t;

endpackage

// ===== fsc_ref_prediv.sv
`timescale 1ns/1ns
module fsc_ref_prediv
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_bit_clock_pin,
  input wire logic [1:0] reference_predivider,
  output logic bit_edge,
  output logic ref_tick
);

  // Whole state of the predivider
  typedef struct packed {
    logic prev;
    logic [2:0] cnt;
    logic edge_q;
    logic tick;
  } fsc_div_st_t;

  fsc_div_st_t st_q;
  fsc_div_st_t st_d;
  logic rise;
  logic [2:0] limit;

  // Divide count from the code; code 1 halves the bit clock
  always_comb begin
    unique case (reference_predivider)
      PREDIV_BY1: limit = PREDIV_CNT1;
      PREDIV_BY2: limit = PREDIV_CNT2;
      PREDIV_BY4: limit = PREDIV_CNT4;
      PREDIV_BY8: limit = PREDIV_CNT8;
    endcase
  end

  assign rise = serial_bit_clock_pin & ~st_q.prev;

  // Count bit clock rising edges, emit one tick every limit+1
  always_comb begin
    st_d = st_q;
    st_d.prev = serial_bit_clock_pin;
    st_d.edge_q = rise;
    st_d.tick = 1'b0;
    if (rise) begin
      if (st_q.cnt >= limit) begin
        st_d.cnt = 3'h0;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bit_edge = st_q.edge_q;
  assign ref_tick = st_q.tick;

endmodule

// ===== fsc_config_sequencer.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Source select 0 bypasses synthesizer; power-down allowed
// - Master clock follows predivider, factors, mode, divider
// - Scale mode 3 bypasses both scale factors
// - Predivider codes 0,2,3 divide by 1,4,8
// - Reference comes from the serial bit clock pin
// - Clearing run powers the synthesizer down
// - Master clock from pin or synthesizer by select
module fsc_config_sequencer
  import fsc_pkg::*;
#(
  parameter int WAIT_CYCLES = SEQ_WAIT_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire fsc_bus_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_bit_clock_pin,
  input wire logic synth_clk_in,
  output fsc_synth_cfg_t synth_cfg,
  output logic synth_ref_tick,
  output logic master_clock_source_select,
  output logic mclk_tick
);

  // Whole state of the block
  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    logic run;
    logic src_sel;
    logic auto_seq;
    logic [1:0] prediv;
    logic [DIV_W-1:0] divout;
    logic [INT_W-1:0] int_f;
    logic [FRAC_W-1:0] frac_f;
    logic [1:0] mode;
    logic [CAL_W-1:0] cal;
    logic [N_W-1:0] ndiv;
    fsc_seq_t seq;
    logic [31:0] timer;
    fsc_synth_cfg_t cfg;
    logic synth_prev;
    logic mclk;
  } fsc_st_t;

  fsc_st_t st_q;
  fsc_st_t st_d;
  logic bit_edge; // One-cycle pulse on each bit clock rise
  logic ref_tick; // Divided reference pulse
  logic req; // A bus request is pending
  logic wr_now; // Write takes effect this edge
  logic [31:0] rd_mux; // Read data selected by address
  logic [31:0] cur; // Current value of the addressed register
  logic [31:0] wmask; // Byte-enable mask
  logic [31:0] merged; // Write data merged over current value
  logic [N_W+DIV_W-1:0] scaled; // Divider times n, full width
  logic run_rise; // Run bit set by this write
  logic synth_rise; // Rising edge of the synthesizer clock

  // Reference divider on the bit clock pin
  fsc_ref_prediv u_prediv (
    .clk(clk),
    .rst(rst),
    .serial_bit_clock_pin(serial_bit_clock_pin),
    .reference_predivider(st_q.prediv),
    .bit_edge(bit_edge),
    .ref_tick(ref_tick)
  );

  assign req = avs_req.read | avs_req.write;
  // The master holds its request until it sees waitrequest low
  assign wr_now = avs_req.write & ~st_q.wait_n;
  // Both operands widened first so the product keeps every bit
  assign scaled = {{N_W{1'b0}}, st_q.divout}
    * {{DIV_W{1'b0}}, st_q.ndiv};
  assign synth_rise = synth_clk_in & ~st_q.synth_prev;

  // Byte-enable mask, one byte lane per generate pass
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{avs_req.byteenable[b]}};
    end
  endgenerate

  // Register read view; unmapped and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_req.address)
      OFF_CTRL: begin
        rd_mux[CTRL_RUN] = st_q.run;
        rd_mux[CTRL_SRC] = st_q.src_sel;
        rd_mux[CTRL_AUTO] = st_q.auto_seq;
      end
      OFF_PREDIV: rd_mux[1:0] = st_q.prediv;
      OFF_DIVOUT: rd_mux[DIV_W-1:0] = st_q.divout;
      OFF_INT: rd_mux[INT_W-1:0] = st_q.int_f;
      OFF_FRAC: rd_mux[FRAC_W-1:0] = st_q.frac_f;
      OFF_MODE: rd_mux[1:0] = st_q.mode;
      OFF_CAL: rd_mux[CAL_W-1:0] = st_q.cal;
      OFF_NDIV: rd_mux[N_W-1:0] = st_q.ndiv;
      OFF_STATUS: begin
        rd_mux[STAT_BUSY] = st_q.seq == SEQ_WAIT;
        rd_mux[STAT_POWER] = st_q.cfg.power_on;
        rd_mux[STAT_DIV_LSB +: DIV_W] = st_q.cfg.out_divider;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // The status word is read-only, so it merges harmlessly
  assign cur = rd_mux;
  assign merged = (avs_req.writedata & wmask) | (cur & ~wmask);
  assign run_rise = wr_now && avs_req.address == OFF_CTRL
    && merged[CTRL_RUN] && !st_q.run;

  // Next-state logic: bus slave, settings, sequencer, clock select
  always_comb begin
    st_d = st_q;
    // One wait cycle, then a single cycle with waitrequest low
    if (req && st_q.wait_n) begin
      st_d.wait_n = 1'b0;
      st_d.rdata = rd_mux;
    end else begin
      st_d.wait_n = 1'b1;
    end
    // Register writes
    if (wr_now) begin
      unique case (avs_req.address)
        OFF_CTRL: begin
          st_d.run = merged[CTRL_RUN];
          st_d.src_sel = merged[CTRL_SRC];
          st_d.auto_seq = merged[CTRL_AUTO];
        end
        OFF_PREDIV: st_d.prediv = merged[1:0];
        OFF_DIVOUT: st_d.divout = merged[DIV_W-1:0];
        OFF_INT: st_d.int_f = merged[INT_W-1:0];
        OFF_FRAC: st_d.frac_f = merged[FRAC_W-1:0];
        OFF_MODE: st_d.mode = merged[1:0];
        OFF_CAL: st_d.cal = merged[CAL_W-1:0];
        OFF_NDIV: st_d.ndiv = merged[N_W-1:0];
        default: st_d.run = st_q.run;
      endcase
    end
    // Factors reach the core at once; software orders the writes
    st_d.cfg.int_factor = st_d.int_f;
    st_d.cfg.frac_factor = st_d.frac_f;
    st_d.cfg.cal_ratio = st_d.cal;
    st_d.cfg.bypass_500 = st_d.mode[MODE_B500_BIT];
    st_d.cfg.bypass_1029 = st_d.mode[MODE_B1029_BIT];
    // Power-up sequencer
    unique case (st_q.seq)
      SEQ_OFF: begin
        st_d.timer = 32'h0;
        if (run_rise && st_d.auto_seq) begin
          // Scaled divider keeps the VCO in range while it settles
          st_d.cfg.out_divider = scaled[DIV_W-1:0];
          st_d.seq = SEQ_WAIT;
        end else if (run_rise) begin
          st_d.cfg.out_divider = st_d.divout;
          st_d.seq = SEQ_RUN;
        end else begin
          st_d.cfg.out_divider = st_d.divout;
        end
      end
      SEQ_WAIT: begin
        if (st_q.timer >= 32'(WAIT_CYCLES - 1)) begin
          st_d.cfg.out_divider = st_d.divout;
          st_d.seq = SEQ_RUN;
        end else begin
          st_d.timer = st_q.timer + 32'h1;
        end
      end
      SEQ_RUN: begin
        st_d.cfg.out_divider = st_d.divout;
      end
    endcase
    // Clearing run powers down from any state
    if (!st_d.run) begin
      st_d.seq = SEQ_OFF;
      st_d.timer = 32'h0;
    end
    st_d.cfg.power_on = st_d.run;
    // Master clock tick from pin edge or from synthesizer edge
    st_d.synth_prev = synth_clk_in;
    if (st_q.src_sel) begin
      st_d.mclk = synth_rise & st_q.cfg.power_on;
    end else begin
      st_d.mclk = bit_edge;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.wait_n <= 1'b1;
      st_q.prediv <= RST_PREDIV;
      st_q.divout <= RST_DIVOUT;
      st_q.int_f <= RST_INT;
      st_q.frac_f <= RST_FRAC;
      st_q.mode <= RST_MODE;
      st_q.cal <= RST_CAL;
      st_q.ndiv <= RST_NDIV;
      st_q.seq <= SEQ_OFF;
      st_q.cfg.int_factor <= RST_INT;
      st_q.cfg.cal_ratio <= RST_CAL;
      st_q.cfg.out_divider <= RST_DIVOUT;
      st_q.cfg.bypass_500 <= RST_MODE[MODE_B500_BIT];
      st_q.cfg.bypass_1029 <= RST_MODE[MODE_B1029_BIT];
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.wait_n;
  assign synth_cfg = st_q.cfg;
  assign synth_ref_tick = ref_tick;
  assign master_clock_source_select = st_q.src_sel;
  assign mclk_tick = st_q.mclk;

  // Checks

  run_power_a: assert property (@(posedge clk) disable iff (rst)
    !st_q.run |-> !synth_cfg.power_on)
    else $error("synth powered while run clear");

  run_clear_a: assert property (@(posedge clk) disable iff (rst)
    $fell(st_q.run) |-> st_q.seq == SEQ_OFF)
    else $error("sequencer not off after run cleared");

  scaled_div_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.seq == SEQ_WAIT) |->
      synth_cfg.out_divider == scaled[DIV_W-1:0])
    else $error("divider not scaled by n at power-up");

  wait_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.seq == SEQ_WAIT) && WAIT_CYCLES > 2 |->
      (st_q.seq == SEQ_WAIT || !st_q.run) [*2])
    else $error("restore wait ended early");

  restore_div_a: assert property (@(posedge clk) disable iff (rst)
    st_q.seq == SEQ_WAIT && st_q.timer >= 32'(WAIT_CYCLES - 1)
      && st_d.run |=> synth_cfg.out_divider == st_q.divout)
    else $error("functional divider not restored");

  wait_time_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.seq == SEQ_RUN) && $past(st_q.seq) == SEQ_WAIT |->
      $past(st_q.timer) == 32'(WAIT_CYCLES - 1))
    else $error("restore before full wait");

  mode_bypass_a: assert property (@(posedge clk) disable iff (rst)
    st_q.mode == MODE_BYPASS_BOTH |->
      synth_cfg.bypass_500 && synth_cfg.bypass_1029)
    else $error("mode 3 does not bypass both factors");

  bypass_src_a: assert property (@(posedge clk) disable iff (rst)
    !st_q.src_sel && bit_edge |=> mclk_tick)
    else $error("bypass does not pass bit clock");

  synth_src_a: assert property (@(posedge clk) disable iff (rst)
    st_q.src_sel && !bit_edge |=> !mclk_tick || $past(synth_rise))
    else $error("master clock tick without synthesizer edge");

  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  factor_pass_a: assert property (@(posedge clk) disable iff (rst)
    synth_cfg.int_factor == st_q.int_f
      && synth_cfg.frac_factor == st_q.frac_f)
    else $error("factors not passed to core");

endmodule

// ===== fsc_clk_src.sv
`timescale 1ns/1ns
// Far side: bit clock master and the synth core output, as sampled levels
module fsc_clk_src #(
  parameter int PIN_HALF = 3, // 8.33 MHz bit clock, inside 2.8-25 MHz
  parameter int SYN_HALF = 2 // Core output, faster than the bit clock
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_en,
  output logic serial_bit_clock_pin,
  output logic synth_clk_in
);
  int pin_cnt; // Half-period counter of the bit clock
  int syn_cnt; // Half-period counter of the core output
  // Bit clock stands low while the master is idle, never runs free
  always_ff @(posedge clk) begin
    if (rst || !pin_en) begin
      pin_cnt <= 0;
      serial_bit_clock_pin <= 1'b0;
    end else if (pin_cnt == PIN_HALF - 1) begin
      pin_cnt <= 0;
      serial_bit_clock_pin <= !serial_bit_clock_pin;
    end else begin
      pin_cnt <= pin_cnt + 1;
    end
  end
  // Core output toggles whenever out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      syn_cnt <= 0;
      synth_clk_in <= 1'b0;
    end else if (syn_cnt == SYN_HALF - 1) begin
      syn_cnt <= 0;
      synth_clk_in <= !synth_clk_in;
    end else begin
      syn_cnt <= syn_cnt + 1;
    end
  end
endmodule

// ===== fsc_config_sequencer_tb.sv
`timescale 1ns/1ns
module fsc_config_sequencer_tb;
  import fsc_pkg::*;
  localparam int WAITC = 20; // Short restore wait for simulation
  localparam int PIN_P = 6; // Bit clock period in clk cycles
  localparam int SYN_P = 4; // Core output period in clk cycles
  logic clk;
  logic rst;
  logic pin_en;
  fsc_bus_req_t req;
  logic [31:0] rdata;
  logic wreq;
  logic pin;
  logic syn;
  fsc_synth_cfg_t cfg;
  logic ref_tick;
  logic sel;
  logic mclk_tick;
  logic [31:0] exp_q [$]; // Expected read data, oldest first
  logic [31:0] seed;
  logic [31:0] r;
  int bad_count;
  int compares;
  int gap;
  // Reset map of every register plus one unmapped word
  logic [5:0] ra [10] = '{OFF_CTRL, OFF_PREDIV, OFF_DIVOUT, OFF_INT,
    OFF_FRAC, OFF_MODE, OFF_CAL, OFF_NDIV, OFF_STATUS, 6'h24};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h10, 32'h40, 32'h0, 32'h3,
    32'h80, 32'h1, 32'h1000, 32'h0};

  fsc_config_sequencer #(.WAIT_CYCLES(WAITC)) i_dut (.clk(clk), .rst(rst),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .serial_bit_clock_pin(pin), .synth_clk_in(syn), .synth_cfg(cfg),
    .synth_ref_tick(ref_tick), .master_clock_source_select(sel),
    .mclk_tick(mclk_tick));
  fsc_clk_src #(.PIN_HALF(PIN_P / 2), .SYN_HALF(SYN_P / 2)) i_src (
    .clk(clk), .rst(rst), .pin_en(pin_en), .serial_bit_clock_pin(pin),
    .synth_clk_in(syn));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One Avalon transfer; starts on a fresh edge so no signal is set twice
  // Waits for the answer with no limit of its own; the watchdog ends a hang
  task automatic bus(input logic is_rd, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{read: is_rd, write: !is_rd, address: a, writedata: d,
             byteenable: 4'hf};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    req <= '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b1, a, 32'h0);
  endtask

  // Synth settings land on the write edge, together with the register
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic tk(input logic which);
    return which ? mclk_tick : synth_ref_tick_w();
  endfunction
  function automatic logic synth_ref_tick_w();
    return ref_tick;
  endfunction

  // Cycles between two ticks; 300 means the tick never came
  task automatic gap_of(input logic which, output int cyc);
    int w;
    w = 0;
    cyc = 0;
    do begin
      @(posedge clk);
      w++;
    end while (tk(which) !== 1'b1 && w < 300);
    do begin
      @(posedge clk);
      cyc++;
    end while (tk(which) !== 1'b1 && cyc < 300);
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Read results are compared when the slave answers
  always @(posedge clk) begin
    if (req.read && wreq === 1'b0) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("ERROR %0t: unexpected read data", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    $display("ERROR %0t: watchdog expired", $time);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    pin_en = 1'b0;
    req = '0;
    seed = 32'h0000800c;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pin_en <= 1'b1;
    settle();
    check(32'(cfg.power_on), 32'h0);
    for (int i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    // Status is read-only and the unmapped word ignores writes
    bus(1'b0, OFF_STATUS, 32'hffffffff);
    bus(1'b0, 6'h24, 32'hffffffff);
    rd(OFF_STATUS, 32'h1000);
    rd(6'h24, 32'h0);
    // Every predivider code; first gap may straddle the change
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFF_PREDIV, 32'(i));
      gap_of(1'b0, gap);
      gap_of(1'b0, gap);
      check(32'(gap), 32'(PIN_P << i));
    end
    check(32'(sel), 32'h0);
    gap_of(1'b1, gap);
    check(32'(gap), 32'(PIN_P));
    // Every scale mode code
    for (int m = 0; m < 4; m++) begin
      bus(1'b0, OFF_MODE, 32'(m));
      settle();
      check(32'({cfg.bypass_1029, cfg.bypass_500}), 32'(m));
    end
    // Random feedback factors and calibration ratio
    for (int k = 0; k < 4; k++) begin
      r = xs();
      bus(1'b0, OFF_INT, r);
      bus(1'b0, OFF_FRAC, r);
      bus(1'b0, OFF_CAL, r >> 8);
      settle();
      check(32'({cfg.int_factor, cfg.frac_factor}), {r[7:0], r[23:0]});
      check(32'(cfg.cal_ratio), 32'(r[15:8]));
    end
    // Power-up in order: 8.33 MHz pin halved to 4.17 MHz reference,
    // times 46 gives 192 MHz core, over 8 gives 24 MHz; ratio 92, n = 2
    bus(1'b0, OFF_PREDIV, 32'h1);
    bus(1'b0, OFF_DIVOUT, 32'h8);
    bus(1'b0, OFF_FRAC, 32'h0);
    bus(1'b0, OFF_INT, 32'h2e);
    bus(1'b0, OFF_MODE, 32'h3);
    bus(1'b0, OFF_CAL, 32'h5c);
    bus(1'b0, OFF_NDIV, 32'h2);
    bus(1'b0, OFF_CTRL, 32'h7);
    settle();
    check(32'({cfg.power_on, cfg.out_divider}), 32'h110);
    check(32'(sel), 32'h1);
    rd(OFF_STATUS, 32'h1003);
    repeat (8) @(posedge clk);
    #1;
    check(32'(cfg.out_divider), 32'h10);
    repeat (WAITC) @(posedge clk);
    #1;
    check(32'(cfg.out_divider), 32'h8);
    rd(OFF_STATUS, 32'h0802);
    gap_of(1'b1, gap);
    gap_of(1'b1, gap);
    check(32'(gap), 32'(SYN_P));
    // Clearing run powers down and silences the synth path
    bus(1'b0, OFF_CTRL, 32'h2);
    settle();
    check(32'(cfg.power_on), 32'h0);
    gap_of(1'b1, gap);
    check(32'(gap), 32'd300);
    // Manual start applies the divider at once
    bus(1'b0, OFF_CTRL, 32'h1);
    settle();
    check(32'({cfg.power_on, cfg.out_divider}), 32'h108);
    // Back to the pin and synth bypassed and off
    bus(1'b0, OFF_CTRL, 32'h0);
    settle();
    check(32'(cfg.power_on), 32'h0);
    gap_of(1'b1, gap);
    gap_of(1'b1, gap);
    check(32'(gap), 32'(PIN_P));
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
